/* core/mss_pkg.sv */
// package of constants and types for the motor start and stall supervisor
package mss_pkg;
   localparam int unsigned CLK_HZ        = 125_000_000;
   localparam int unsigned DET_WIN_MS    = 10;
   localparam int unsigned DET_WIN_CYC   = (CLK_HZ / 1000) * DET_WIN_MS;
   localparam int unsigned TICK_US       = 1000;
   localparam int unsigned TICK_CYC      = (CLK_HZ / 1_000_000) * TICK_US;
   localparam logic [7:0] ADR_CTRL       = 8'h00;
   localparam logic [7:0] ADR_START_T    = 8'h04;
   localparam logic [7:0] ADR_STALL_HOT  = 8'h08;
   localparam logic [7:0] ADR_STALL_COLD = 8'h0c;
   localparam logic [7:0] ADR_NOLOAD     = 8'h10;
   localparam logic [7:0] ADR_DETECT     = 8'h14;
   localparam logic [7:0] ADR_NOM_START  = 8'h18;
   localparam logic [7:0] ADR_STATUS     = 8'h1c;
   localparam logic [7:0] ADR_IRQ_STAT   = 8'h20;
   localparam logic [7:0] ADR_IRQ_MASK   = 8'h24;
   localparam logic [7:0] ADR_ELAPSED    = 8'h28;
   localparam int unsigned CTRL_INV_BIT  = 0;
   localparam int unsigned CTRL_AUTO_BIT = 1;
   localparam int unsigned CTRL_SPD_EN   = 2;
   localparam int unsigned CTRL_SPD_SEL  = 3;
   localparam int unsigned CTRL_METH_LO  = 5;
   localparam int unsigned CTRL_STALLMON = 7;
   localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
   localparam logic [15:0] START_T_RST   = 16'h2710;
   localparam logic [15:0] STALL_T_RST   = 16'h3a98;
   localparam logic [15:0] NOLOAD_RST    = 16'h0020;
   localparam logic [15:0] DETECT_RST    = 16'h0180;
   localparam logic [15:0] NOM_START_RST = 16'h0600;
   localparam int unsigned EV_START      = 0;
   localparam int unsigned EV_TRIP_START = 1;
   localparam int unsigned EV_TRIP_STALL = 2;
   localparam int unsigned EV_STALL      = 3;
   localparam int unsigned NEV           = 4;

   typedef enum logic [1:0] {
      MSS_DOL = 2'h0, MSS_STAR_DELTA = 2'h1, MSS_SOFT = 2'h2
   } mss_method_e;

   typedef enum logic [3:0] {
      ST_STOPPED = 4'h1, ST_STARTING = 4'h2, ST_RUNNING = 4'h4,
      ST_TRIPPED = 4'h8
   } mss_state_e;

   typedef struct packed {
      logic [15:0] i_meas;
      logic        valid;
   } mss_cur_s;

   typedef struct packed {
      logic [15:0] stall_hot;
      logic [15:0] stall_cold;
      logic        hot;
   } mss_therm_s;
endpackage : mss_pkg

/* core/mss_supervisor.sv */
// motor start and locked rotor supervisor with wishbone registers
`timescale 1ns/1ps
module mss_supervisor #(
   parameter int unsigned TICK_CYCLES = mss_pkg::TICK_CYC,
   parameter int unsigned DET_CYCLES  = mss_pkg::DET_WIN_CYC
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [7:0]        wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   input  wire mss_pkg::mss_cur_s   cur_i,
   input  wire mss_pkg::mss_therm_s therm_i,
   input  wire logic [1:0]        speed_sw_i,
   output logic                   trip_o,
   output logic                   starting_o,
   output logic                   irq_o
);
   import mss_pkg::*;

   initial begin
      if (TICK_CYCLES < 2 || DET_CYCLES < 2) begin
         $error("mss_supervisor: tick and window must be at least 2");
      end
   end

   // registers
   logic [31:0] ctrl_q;
   logic [15:0] start_t_q, hot_t_q, cold_t_q, noload_q, detect_q, nom_q;
   logic [NEV-1:0] ist_q, imask_q;
   mss_state_e  state_q;
   logic [15:0] elapsed_q;
   logic [47:0] acc_q;
   logic [1:0]  spd_s1_q, spd_s2_q;
   logic [31:0] tick_cnt_q, det_cnt_q;
   logic        tick_q, det_arm_q, stall_q;
   logic [NEV-1:0] ev;

   wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire wb_wr  = wb_req && wb_we_i;

   // bus slave answers one cycle after the request
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         if (wb_req && !wb_we_i) begin
            case (wb_adr_i)
               ADR_CTRL:       wb_dat_o <= ctrl_q;
               ADR_START_T:    wb_dat_o <= {16'h0000, start_t_q};
               ADR_STALL_HOT:  wb_dat_o <= {16'h0000, hot_t_q};
               ADR_STALL_COLD: wb_dat_o <= {16'h0000, cold_t_q};
               ADR_NOLOAD:     wb_dat_o <= {16'h0000, noload_q};
               ADR_DETECT:     wb_dat_o <= {16'h0000, detect_q};
               ADR_NOM_START:  wb_dat_o <= {16'h0000, nom_q};
               ADR_STATUS:     wb_dat_o <= {24'h000000, stall_q,
                                  spd_s2_q, trip_o, state_q};
               ADR_IRQ_STAT:   wb_dat_o <= {28'h0000000, ist_q};
               ADR_IRQ_MASK:   wb_dat_o <= {28'h0000000, imask_q};
               ADR_ELAPSED:    wb_dat_o <= {16'h0000, elapsed_q};
               default:        wb_dat_o <= 32'h0000_0000;
            endcase
         end
      end
   end

   // byte-lane writes of the setting registers
   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  s);
      logic [15:0] r;
      r = old;
      if (s[0]) r[7:0] = d[7:0];
      if (s[1]) r[15:8] = d[15:8];
      return r;
   endfunction : wr16

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_q    <= CTRL_RST;
         start_t_q <= START_T_RST;
         hot_t_q   <= STALL_T_RST;
         cold_t_q  <= STALL_T_RST;
         noload_q  <= NOLOAD_RST;
         detect_q  <= DETECT_RST;
         nom_q     <= NOM_START_RST;
         imask_q   <= '0;
      end else if (wb_wr) begin
         case (wb_adr_i)
            ADR_CTRL: begin
               for (int b = 0; b < 4; b++) begin
                  if (wb_sel_i[b]) ctrl_q[8*b +: 8] <= wb_dat_i[8*b +: 8];
               end
            end
            ADR_START_T:    start_t_q <= wr16(start_t_q, wb_dat_i, wb_sel_i);
            ADR_STALL_HOT:  hot_t_q   <= wr16(hot_t_q, wb_dat_i, wb_sel_i);
            ADR_STALL_COLD: cold_t_q  <= wr16(cold_t_q, wb_dat_i, wb_sel_i);
            ADR_NOLOAD:     noload_q  <= wr16(noload_q, wb_dat_i, wb_sel_i);
            ADR_DETECT:     detect_q  <= wr16(detect_q, wb_dat_i, wb_sel_i);
            ADR_NOM_START:  nom_q     <= wr16(nom_q, wb_dat_i, wb_sel_i);
            ADR_IRQ_MASK: begin
               if (wb_sel_i[0]) imask_q <= wb_dat_i[NEV-1:0];
            end
            default: ;
         endcase
      end
   end

   wire inv_mode  = ctrl_q[CTRL_INV_BIT];
   wire auto_st   = ctrl_q[CTRL_AUTO_BIT];
   wire spd_en    = ctrl_q[CTRL_SPD_EN];
   wire spd_sel   = ctrl_q[CTRL_SPD_SEL];
   wire stall_mon = ctrl_q[CTRL_STALLMON];
   wire mss_method_e meth = mss_method_e'(ctrl_q[CTRL_METH_LO +: 2]);

   // speed switch inputs come from pins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         spd_s1_q <= 2'h0;
         spd_s2_q <= 2'h0;
      end else begin
         spd_s1_q <= speed_sw_i;
         spd_s2_q <= spd_s1_q;
      end
   end
   wire rotating = spd_en && spd_s2_q[spd_sel];

   // stall time follows the thermal state when tracking is on
   wire [15:0] safe_stall = !auto_st ? hot_t_q :
                            therm_i.hot ? therm_i.stall_hot :
                            therm_i.stall_cold;
   wire [15:0] max_start = auto_st ? safe_stall : start_t_q;

   wire [15:0] i_now  = cur_i.i_meas;
   wire above_noload  = i_now > noload_q;
   wire above_detect  = i_now > detect_q;

   // millisecond time base
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b0;
      end else if (tick_cnt_q == TICK_CYCLES - 1) begin
         tick_cnt_q <= 32'h0;
         tick_q     <= 1'b1;
      end else begin
         tick_cnt_q <= tick_cnt_q + 32'h1;
         tick_q     <= 1'b0;
      end
   end

   // detection window opens when current leaves the no-load band
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         det_arm_q <= 1'b0;
         det_cnt_q <= 32'h0;
      end else if (state_q != ST_STOPPED || !above_noload) begin
         det_arm_q <= 1'b0;
         det_cnt_q <= 32'h0;
      end else if (!det_arm_q) begin
         det_arm_q <= 1'b1;
         det_cnt_q <= 32'h0;
      end else if (det_cnt_q < DET_CYCLES) begin
         det_cnt_q <= det_cnt_q + 32'h1;
      end
   end
   // a slow rise never counts as a start; soft start skips the window
   wire start_det = state_q == ST_STOPPED && cur_i.valid && above_detect &&
                    (meth == MSS_SOFT ||
                     (det_arm_q && det_cnt_q < DET_CYCLES));

   // i2t allowance: nominal start current squared times allowed time;
   // lower current accumulates slower so the start may last longer
   wire [31:0] i_sq      = i_now * i_now;
   wire [31:0] nom_sq    = nom_q * nom_q;
   wire [47:0] allowance = nom_sq * max_start;
   wire        sup_run   = state_q == ST_STARTING || stall_q;
   wire        over_def  = elapsed_q >= max_start;
   wire        over_inv  = acc_q > allowance;
   wire        over_lim  = inv_mode ? over_inv : over_def;
   wire        over_safe = elapsed_q >= safe_stall;
   wire        trip_now  = sup_run &&
                           ((over_lim && !rotating) ||
                            (rotating && over_safe));
   wire        cond_end  = !above_noload || !cur_i.valid;
   wire        stall_in  = stall_mon && state_q == ST_RUNNING &&
                           i_now > nom_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         elapsed_q <= 16'h0;
         acc_q     <= 48'h0;
      end else if (!sup_run) begin
         elapsed_q <= 16'h0;
         acc_q     <= 48'h0;
      end else if (tick_q) begin
         if (elapsed_q != 16'hffff) elapsed_q <= elapsed_q + 16'h1;
         if (!acc_q[47]) acc_q <= acc_q + {16'h0, i_sq};
      end
   end

   // supervision state machine
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_q <= ST_STOPPED;
         stall_q <= 1'b0;
         trip_o  <= 1'b0;
      end else begin
         case (state_q)
            ST_STOPPED: begin
               stall_q <= 1'b0;
               if (start_det) state_q <= ST_STARTING;
               // only a rise that missed the window counts as running
               else if (above_noload && det_arm_q &&
                        det_cnt_q >= DET_CYCLES) state_q <= ST_RUNNING;
            end
            ST_STARTING: begin
               if (trip_now) begin
                  state_q <= ST_TRIPPED;
                  trip_o  <= 1'b1;
               end else if (cond_end) state_q <= ST_STOPPED;
               else if (i_now <= nom_q) state_q <= ST_RUNNING;
            end
            ST_RUNNING: begin
               if (cond_end) begin
                  state_q <= ST_STOPPED;
                  stall_q <= 1'b0;
               end else if (trip_now) begin
                  state_q <= ST_TRIPPED;
                  trip_o  <= 1'b1;
               end else begin
                  stall_q <= stall_in;
               end
            end
            ST_TRIPPED: begin
               // held until the current falls to no-load or below, or the measurement goes invalid
               if (cond_end) begin
                  state_q <= ST_STOPPED;
                  trip_o  <= 1'b0;
                  stall_q <= 1'b0;
               end
            end
            default: begin
               state_q <= ST_STOPPED;
               trip_o  <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) starting_o <= 1'b0;
      else starting_o <= state_q == ST_STARTING;
   end

   // events and interrupt; a new event wins over a clear
   always_comb begin
      ev = '0;
      ev[EV_START]      = start_det;
      ev[EV_TRIP_START] = trip_now && state_q == ST_STARTING;
      ev[EV_TRIP_STALL] = trip_now && state_q == ST_RUNNING;
      ev[EV_STALL]      = stall_in && !stall_q && state_q == ST_RUNNING;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ist_q <= '0;
      end else begin
         if (wb_wr && wb_adr_i == ADR_IRQ_STAT && wb_sel_i[0])
            ist_q <= (ist_q & ~wb_dat_i[NEV-1:0]) | ev;
         else
            ist_q <= ist_q | ev;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) irq_o <= 1'b0;
      else irq_o <= |(ist_q & imask_q);
   end
endmodule : mss_supervisor

/* testbench/mss_plant.sv */
// far-side model: current sensor, breaker, speed switch, thermal function
`timescale 1ns/1ps
module mss_plant import mss_pkg::*; (
   input  wire logic        clk_i,
   input  wire logic [15:0] lvl_i,
   input  wire logic        rot_i,
   input  wire logic        hot_i,
   input  wire logic        trip_i,
   output mss_cur_s         cur_o,
   output mss_therm_s       therm_o,
   output logic [1:0]       spd_o
);
   logic open_q = 1'b0;
   initial begin
      cur_o = '0;
      therm_o = '0;
      spd_o = 2'h0;
   end
   // breaker stays open until the bench removes the load, so no restart
   always @(posedge clk_i) begin
      if (trip_i) begin
         open_q <= 1'b1;
      end else if (lvl_i == 16'h0000) begin
         open_q <= 1'b0;
      end
      cur_o <= '{i_meas: (open_q || trip_i) ? 16'h0000 : lvl_i, valid: 1'b1};
      therm_o <= '{16'h0003, 16'h0009, hot_i};
      spd_o <= {~spd_o[1], rot_i}; // unselected pin toggles, never idles
   end
endmodule : mss_plant

/* testbench/mss_supervisor_sva.sv */
// port-level assertion checker for the motor start and stall supervisor
`timescale 1ns/1ps
module mss_supervisor_sva import mss_pkg::*; #(
   parameter int unsigned TICK_CYCLES = 10,
   parameter int unsigned DET_CYCLES  = 20
) (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire mss_cur_s    cur_i,
   input wire logic        trip_o,
   input wire logic        starting_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_trip_rise;
      $rose(trip_o);
   endsequence
   a_ack_follows_req: assert property (s_req |=> wb_ack_o)
      else $error("ack missing after request");
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_rdata_held: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i)
      |=> $stable(wb_dat_o))
      else $error("read data changed without read");
   a_start_cause: assert property ($rose(starting_o)
      |-> $past(cur_i.valid && cur_i.i_meas != 16'h0000, 2))
      else $error("start flagged without current");
   a_trip_ends_start: assert property (s_trip_rise |-> ##[0:1] !starting_o)
      else $error("start not ended by trip");
   a_trip_cause: assert property (s_trip_rise
      |-> $past(cur_i.i_meas != 16'h0000))
      else $error("trip without current");
   a_trip_release: assert property (trip_o && (!cur_i.valid
      || cur_i.i_meas == 16'h0000) |=> !trip_o)
      else $error("trip held after current gone");
endmodule : mss_supervisor_sva
bind mss_supervisor mss_supervisor_sva #(.TICK_CYCLES(TICK_CYCLES),
   .DET_CYCLES(DET_CYCLES)) u_sva (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_dat_o, .wb_ack_o, .cur_i, .trip_o, .starting_o);

/* testbench/mss_supervisor_tb.sv */
// self-checking bench for the motor start and stall supervisor
`timescale 1ns/1ps
module mss_supervisor_tb;
   import mss_pkg::*;
   logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
   logic        rot = 1'b0, hot = 1'b0, ack, trip, starting, irq;
   logic [7:0]  adr = 8'h00;
   logic [31:0] dat = 32'h0, rdat;
   logic [15:0] lvl = 16'h0000;
   logic [1:0]  spd;
   mss_cur_s    cur;
   mss_therm_s  therm;
   int          failures = 0, total_checks = 0;
   always #4 clk_i = ~clk_i;
   mss_supervisor #(.TICK_CYCLES(10), .DET_CYCLES(20)) u_dut (.clk_i,
      .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(4'hf), .wb_dat_o(rdat), .wb_ack_o(ack),
      .cur_i(cur), .therm_i(therm), .speed_sw_i(spd), .trip_o(trip),
      .starting_o(starting), .irq_o(irq));
   mss_plant u_plant (.clk_i, .lvl_i(lvl), .rot_i(rot), .hot_i(hot),
      .trip_i(trip), .cur_o(cur), .therm_o(therm), .spd_o(spd));
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         failures++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (ack !== 1'b1);
      cyc <= 1'b0;
      we <= 1'b0;
   endtask : wb
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(a, 1'b0, 32'h0);
      chk($sformatf("read %h", a), e, rdat);
   endtask : rd
   // quiet: cycles in which no trip may come; lim: further wait for it
   task run(input logic [15:0] l, input int quiet, input int lim);
      int n;
      n = 0;
      lvl <= l;
      repeat (quiet) @(posedge clk_i);
      chk("starting", 32'h1, {31'h0, starting});
      chk("early trip", 32'h0, {31'h0, trip});
      while (trip !== 1'b1 && n < lim) begin
         @(posedge clk_i);
         n++;
      end
      chk("trip", 32'h1, {31'h0, trip});
      lvl <= 16'h0000;
      repeat (4) @(posedge clk_i);
      chk("trip release", 32'h0, {31'h0, trip});
   endtask : run
   task results;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : results
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rd(ADR_CTRL, CTRL_RST);
      rd(ADR_START_T, {16'h0, START_T_RST});
      rd(ADR_STALL_HOT, {16'h0, STALL_T_RST});
      rd(8'h3c, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wb(ADR_CTRL, 1'b1, 32'(m) << 5);
         rd(ADR_CTRL, 32'(m) << 5);
      end
      wb(ADR_CTRL, 1'b1, 32'h0);
      wb(ADR_START_T, 1'b1, 32'h5);
      wb(ADR_STALL_HOT, 1'b1, 32'hc);
      wb(ADR_DETECT, 1'b1, 32'h100);
      wb(ADR_NOM_START, 1'b1, 32'h100);
      wb(ADR_IRQ_MASK, 1'b1, 32'h2);
      run(16'h0200, 30, 60);
      chk("irq", 32'h1, {31'h0, irq});
      rd(ADR_IRQ_STAT, 32'h3);
      wb(ADR_IRQ_STAT, 1'b1, 32'h3);
      rd(ADR_IRQ_STAT, 32'h0);
      chk("irq clear", 32'h0, {31'h0, irq});
      rot <= 1'b1;
      wb(ADR_CTRL, 1'b1, 32'h4);
      run(16'h0200, 80, 70);
      rot <= 1'b0;
      wb(ADR_CTRL, 1'b1, 32'h1);
      wb(ADR_START_T, 1'b1, 32'h8);
      run(16'h0200, 15, 40);
      run(16'h0120, 55, 40);
      hot <= 1'b1;
      wb(ADR_CTRL, 1'b1, 32'h2);
      run(16'h0200, 15, 40);
      hot <= 1'b0;
      run(16'h0200, 60, 60);
      wb(ADR_CTRL, 1'b1, 32'h0);
      lvl <= 16'h0040;
      repeat (30) @(posedge clk_i);
      lvl <= 16'h0200;
      repeat (5) @(posedge clk_i);
      chk("slow rise", 32'h0, {31'h0, starting});
      lvl <= 16'h0000;
      repeat (4) @(posedge clk_i);
      wb(ADR_IRQ_STAT, 1'b1, 32'hf);
      wb(ADR_CTRL, 1'b1, 32'h80);
      lvl <= 16'h0200;
      repeat (10) @(posedge clk_i);
      lvl <= 16'h0080;
      repeat (10) @(posedge clk_i);
      chk("run after start", 32'h0, {31'h0, starting});
      lvl <= 16'h0200;
      repeat (30) @(posedge clk_i);
      chk("early stall trip", 32'h0, {31'h0, trip});
      for (int n = 0; n < 120 && trip !== 1'b1; n++) @(posedge clk_i);
      chk("stall trip", 32'h1, {31'h0, trip});
      lvl <= 16'h0000;
      repeat (4) @(posedge clk_i);
      rd(ADR_IRQ_STAT, 32'hd);
      chk("irq masked", 32'h0, {31'h0, irq});
      results;
   end
   initial begin
      repeat (20000) @(posedge clk_i);
      failures++;
      results;
   end
endmodule : mss_supervisor_tb
